// ==== hw/t16wm_defines.vh ====
`ifndef T16WM_DEFINES_VH
`define T16WM_DEFINES_VH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define T16WM_ADDR_CTRL_A   12'h000
`define T16WM_ADDR_CTRL_B   12'h004
`define T16WM_ADDR_COUNT    12'h008
`define T16WM_ADDR_CMP_A    12'h00C
`define T16WM_ADDR_CMP_B    12'h010
`define T16WM_ADDR_CAPTURE  12'h014
`define T16WM_ADDR_STATUS   12'h018
`define T16WM_ADDR_PINCTL   12'h01C

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define T16WM_OMA_HI        7
`define T16WM_OMA_LO        6
`define T16WM_OMB_HI        5
`define T16WM_OMB_LO        4
`define T16WM_WML_HI        1
`define T16WM_WML_LO        0
`define T16WM_WMH_HI        4
`define T16WM_WMH_LO        3
`define T16WM_ST_OVF        0
`define T16WM_ST_CMA        1
`define T16WM_ST_CMB        2
`define T16WM_PC_DIRA       0
`define T16WM_PC_DIRB       1

// ---------------------------------------------------------------
// Values
// ---------------------------------------------------------------
`define T16WM_RST8          8'h00
`define T16WM_RST16         16'h0000
`define T16WM_BOTTOM        16'h0000
`define T16WM_MAX           16'hFFFF
`define T16WM_TOP8          16'h00FF
`define T16WM_TOP9          16'h01FF
`define T16WM_TOP10         16'h03FF
`define T16WM_ONE16         16'h0001

`endif

// ==== hw/t16wm_timer.v ====
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
// Overview of operation
// [R1] Everything runs on i_clock; counting and updates happen only when tick is high. Count writes, and normal-mode compare writes, land without a tick.
// [R2] Phase-and-frequency-correct modes load compare buffers at BOTTOM.
// [R3] Output mode fields A bits 7:6, B bits 5:4; nonzero takes the pin.
// [R4] Pin is driven only while its direction bit selects output.
// [R5] Non-PWM: 0 off, 1 toggle, 2 clear, 3 set on compare match.
// [R6] Fast PWM: 2 clears on match sets at BOTTOM; 3 is inverse.
// [R7] PWM value 1: off unless mode bit3 set; then A toggles, B reserved.
// [R8] Fast PWM: match at TOP ignored when high output mode bit set; BOTTOM action kept.
// [R9] Dual-slope: 2 clears on up match, sets on down match; 3 inverse.
// [R10] Four-bit mode from control_reg_a bits 1:0 and control_reg_b; 13 reserved.
// [R11] Phase-correct 1,2,3,10,11: fixed or register TOP, load at TOP, flag at BOTTOM.
// [R12] Fast PWM 5,6,7,14,15: fixed or register TOP, load at BOTTOM, flag at TOP.
// [R13] Modes 0,4,12: TOP 0xFFFF, compare A, capture; immediate load; flag at MAX.
// [R14] Modes 8 and 9: TOP capture or compare A; load and flag at BOTTOM.
// [R15] Dual-slope counts up from zero to TOP then back down, repeatedly.
// [R16] Dual-slope, mode 2: compare at BOTTOM gives constant low, at TOP constant high; 3 inverse.
// [R17] Reset leaves output modes and waveform mode zero: normal, pins released.
module t16wm_timer (
    // Clock and reset
    input  wire        i_clock,
    input  wire        i_sys_rst,
    // Timer tick
    input  wire        i_tick,
    // APB slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    // Compare output pins
    output reg         o_cmp_a_out,
    output reg         o_cmp_a_oe_n,
    output reg         o_cmp_b_out,
    output reg         o_cmp_b_oe_n,
    // Pin takeover indication
    output reg         o_cmp_a_own,
    output reg         o_cmp_b_own
);
`include "t16wm_defines.vh"

    // ---------------------------------------------------------------
    // Mode classes
    // ---------------------------------------------------------------
    localparam CL_NORMAL = 2'b00;
    localparam CL_FAST   = 2'b01;
    localparam CL_PC     = 2'b10;
    localparam CL_PFC    = 2'b11;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    reg  [7:0]  ctrl_a_r;
    reg  [1:0]  wm_high_r;
    reg  [15:0] count_r;
    reg  [15:0] cmp_a_buf_r;
    reg  [15:0] cmp_b_buf_r;
    reg  [15:0] cmp_a_r;
    reg  [15:0] cmp_b_r;
    reg  [15:0] capture_r;
    reg  [2:0]  status_r;
    reg  [1:0]  dir_r;
    reg         down_r;
    reg         wave_a_r;
    reg         wave_b_r;

    wire [3:0]  wmode = {wm_high_r, ctrl_a_r[`T16WM_WML_HI:`T16WM_WML_LO]}; // [R10]
    wire [1:0]  om_a  = ctrl_a_r[`T16WM_OMA_HI:`T16WM_OMA_LO];
    wire [1:0]  om_b  = ctrl_a_r[`T16WM_OMB_HI:`T16WM_OMB_LO];

    // ---------------------------------------------------------------
    // Mode decoding
    // ---------------------------------------------------------------
    function [1:0] mode_class;
        input [3:0] m;
        begin
            case (m)
                4'h1, 4'h2, 4'h3, 4'hA, 4'hB: mode_class = CL_PC;
                4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_class = CL_FAST;
                4'h8, 4'h9:                   mode_class = CL_PFC;
                default:                      mode_class = CL_NORMAL;
            endcase
        end
    endfunction

    // Mode 13 is reserved; treated as normal counting here
    function [15:0] top_of;
        input [3:0]  m;
        input [15:0] cap;
        input [15:0] cmpa;
        begin
            case (m)
                4'h1, 4'h5:             top_of = `T16WM_TOP8;   // [R11] [R12]
                4'h2, 4'h6:             top_of = `T16WM_TOP9;
                4'h3, 4'h7:             top_of = `T16WM_TOP10;
                4'h4, 4'h9, 4'hB, 4'hF: top_of = cmpa;          // [R13] [R14]
                4'h8, 4'hA, 4'hC, 4'hE: top_of = cap;
                default:                top_of = `T16WM_MAX;
            endcase
        end
    endfunction

    // Next pin level for one channel on this tick
    function wave_next;
        input       cur;
        input [1:0] om;
        input [1:0] cls;
        input       bit3;
        input       chan_a;
        input       match;
        input       at_bottom;
        input       is_top;
        input       going_down;
        begin
            wave_next = cur;
            if (om == 2'b01) begin
                if (match && (cls == CL_NORMAL || (bit3 && chan_a))) // [R5] [R7]
                    wave_next = ~cur;
            end else if (om[1]) begin
                case (cls)
                    CL_NORMAL: if (match) wave_next = om[0];  // [R5]
                    CL_FAST: begin
                        if (at_bottom) wave_next = ~om[0];    // [R6]
                        if (match && !is_top) wave_next = om[0]; // [R8]
                    end
                    default:
                        if (match) wave_next = going_down ? ~om[0] : om[0]; // [R9] [R16]
                endcase
            end
        end
    endfunction

    wire [1:0]  cls      = mode_class(wmode);
    wire [15:0] top      = top_of(wmode, capture_r, cmp_a_r);
    wire        at_top   = (count_r == top);
    wire        at_bot   = (count_r == `T16WM_BOTTOM);
    wire        dual     = cls[1];
    // Direction the counter is moving on this tick
    wire        going_dn = dual && (down_r || at_top) && !at_bot;
    wire        match_a  = (count_r == cmp_a_r);
    wire        match_b  = (count_r == cmp_b_r);

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    // First access edge raises pready; the next edge closes the transfer
    wire        acc     = i_psel && i_penable && !o_pready;
    wire        done    = i_psel && i_penable && o_pready;
    // Writes land only where the master samples pready high
    wire        wr      = done && i_pwrite;
    wire        known   = (i_paddr == `T16WM_ADDR_CTRL_A) || (i_paddr == `T16WM_ADDR_CTRL_B)
                       || (i_paddr == `T16WM_ADDR_COUNT) || (i_paddr == `T16WM_ADDR_CMP_A)
                       || (i_paddr == `T16WM_ADDR_CMP_B) || (i_paddr == `T16WM_ADDR_CAPTURE)
                       || (i_paddr == `T16WM_ADDR_STATUS) || (i_paddr == `T16WM_ADDR_PINCTL);
    wire        wr_cnt  = wr && (i_paddr == `T16WM_ADDR_COUNT);
    wire        wr_cma  = wr && (i_paddr == `T16WM_ADDR_CMP_A);
    wire        wr_cmb  = wr && (i_paddr == `T16WM_ADDR_CMP_B);
    wire        wr_st   = wr && (i_paddr == `T16WM_ADDR_STATUS);

    reg  [31:0] rdata_nxt;
    always @* begin
        case (i_paddr)
            `T16WM_ADDR_CTRL_A:  rdata_nxt = {24'h000000, ctrl_a_r};
            `T16WM_ADDR_CTRL_B:  rdata_nxt = {27'h0000000, wm_high_r, 3'h0};
            `T16WM_ADDR_COUNT:   rdata_nxt = {16'h0000, count_r};
            `T16WM_ADDR_CMP_A:   rdata_nxt = {16'h0000, cmp_a_buf_r};
            `T16WM_ADDR_CMP_B:   rdata_nxt = {16'h0000, cmp_b_buf_r};
            `T16WM_ADDR_CAPTURE: rdata_nxt = {16'h0000, capture_r};
            `T16WM_ADDR_STATUS:  rdata_nxt = {29'h00000000, status_r};
            `T16WM_ADDR_PINCTL:  rdata_nxt = {30'h00000000, dir_r};
            default:             rdata_nxt = 32'h00000000;
        endcase
    end

    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_prdata  <= 32'h00000000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= acc;
            o_pslverr <= acc && !known;
            o_prdata  <= (acc && !i_pwrite) ? rdata_nxt : 32'h00000000;
        end
    end

    // ---------------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------------
    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_a_r  <= `T16WM_RST8;  // [R17]
            wm_high_r <= 2'h0;
            capture_r <= `T16WM_RST16;
            dir_r     <= 2'h0;
        end else begin
            // Bits 3:2 hold nothing here and read back as zero
            if (wr && i_paddr == `T16WM_ADDR_CTRL_A)
                ctrl_a_r <= {i_pwdata[`T16WM_OMA_HI:`T16WM_OMB_LO], 2'h0,
                             i_pwdata[`T16WM_WML_HI:`T16WM_WML_LO]};
            if (wr && i_paddr == `T16WM_ADDR_CTRL_B)
                wm_high_r <= i_pwdata[`T16WM_WMH_HI:`T16WM_WMH_LO]; // [R10]
            if (wr && i_paddr == `T16WM_ADDR_CAPTURE)
                capture_r <= i_pwdata[15:0];
            if (wr && i_paddr == `T16WM_ADDR_PINCTL)
                dir_r <= i_pwdata[1:0];
        end
    end

    // ---------------------------------------------------------------
    // Counter, compare buffers, flags
    // ---------------------------------------------------------------
    wire        load_now = (cls == CL_NORMAL) ? 1'b1               // [R13]
                         : (cls == CL_PC)     ? at_top             // [R11]
                         : at_bot;                                 // [R2] [R12] [R14]
    wire        ovf_ev   = (cls == CL_NORMAL) ? (count_r == `T16WM_MAX) // [R13]
                         : (cls == CL_FAST)   ? at_top                  // [R12]
                         : (at_bot && down_r);                          // [R11] [R14]
    reg  [15:0] count_nxt;
    always @* begin
        if (dual)
            count_nxt = going_dn ? count_r - `T16WM_ONE16 : count_r + `T16WM_ONE16; // [R15]
        else if (at_top && cls != CL_NORMAL)
            count_nxt = `T16WM_BOTTOM;
        else if (cls == CL_NORMAL && wmode != 4'h0 && wmode != 4'hD && at_top)
            count_nxt = `T16WM_BOTTOM;
        else
            count_nxt = count_r + `T16WM_ONE16;
    end

    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            count_r     <= `T16WM_RST16;
            down_r      <= 1'b0;
            cmp_a_buf_r <= `T16WM_RST16;
            cmp_b_buf_r <= `T16WM_RST16;
            cmp_a_r     <= `T16WM_RST16;
            cmp_b_r     <= `T16WM_RST16;
            status_r    <= 3'h0;
        end else begin
            if (wr_cma)
                cmp_a_buf_r <= i_pwdata[15:0];
            if (wr_cmb)
                cmp_b_buf_r <= i_pwdata[15:0];
            // Immediate modes copy straight through; others wait for the load point
            if (cls == CL_NORMAL) begin
                if (wr_cma) cmp_a_r <= i_pwdata[15:0];
                if (wr_cmb) cmp_b_r <= i_pwdata[15:0];
            end else if (i_tick && load_now) begin
                cmp_a_r <= cmp_a_buf_r;
                cmp_b_r <= cmp_b_buf_r;
            end
            // A count write wins over the tick so software can park the counter
            if (wr_cnt)
                count_r <= i_pwdata[15:0];
            else if (i_tick) begin                                  // [R1]
                count_r <= count_nxt;
                down_r  <= dual && going_dn;
            end
            // Write-one clears; a same-cycle event wins
            status_r <= (wr_st ? status_r & ~i_pwdata[2:0] : status_r)
                      | ({i_tick && match_b, i_tick && match_a, i_tick && ovf_ev});
        end
    end

    // ---------------------------------------------------------------
    // Waveform outputs
    // ---------------------------------------------------------------
    wire fast_top_a = (cls == CL_FAST) && at_top && om_a[1];
    wire fast_top_b = (cls == CL_FAST) && at_top && om_b[1];

    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wave_a_r     <= 1'b0;
            wave_b_r     <= 1'b0;
            o_cmp_a_out  <= 1'b0;
            o_cmp_b_out  <= 1'b0;
            o_cmp_a_oe_n <= 1'b1;
            o_cmp_b_oe_n <= 1'b1;
            o_cmp_a_own  <= 1'b0;
            o_cmp_b_own  <= 1'b0;
        end else begin
            // Bottom action rides the wrap tick, so wave register and counter reach BOTTOM together; the pin follows one clock later
            if (i_tick && !wr_cnt) begin                            // [R1]
                wave_a_r <= wave_next(wave_a_r, om_a, cls, wmode[3], 1'b1,
                                      match_a, at_top, fast_top_a, going_dn);
                wave_b_r <= wave_next(wave_b_r, om_b, cls, wmode[3], 1'b0,
                                      match_b, at_top, fast_top_b, going_dn);
            end
            o_cmp_a_out  <= wave_a_r;
            o_cmp_b_out  <= wave_b_r;
            o_cmp_a_own  <= (om_a != 2'b00);                        // [R3]
            o_cmp_b_own  <= (om_b != 2'b00);
            o_cmp_a_oe_n <= !((om_a != 2'b00) && dir_r[`T16WM_PC_DIRA]); // [R4]
            o_cmp_b_oe_n <= !((om_b != 2'b00) && dir_r[`T16WM_PC_DIRB]);
        end
    end

endmodule // t16wm_timer

// ==== verif/t16wm_assertions.sv ====
`timescale 1ns/100ps
`include "t16wm_defines.vh"
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module t16wm_chk (
    // Clock, reset, tick
    input wire        i_clock,
    input wire        i_sys_rst,
    input wire        i_tick,
    // APB
    input wire        i_psel,
    input wire        i_penable,
    input wire        i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire        o_pready,
    input wire        o_pslverr,
    // Pins
    input wire        o_cmp_a_out,
    input wire        o_cmp_a_oe_n,
    input wire        o_cmp_b_out,
    input wire        o_cmp_b_oe_n,
    input wire        o_cmp_a_own,
    input wire        o_cmp_b_own
);
    reg  [1:0] oma_r;
    reg  [1:0] omb_r;
    reg        dira_r;
    reg        dirb_r;
    wire       take_w;
    wire       cfg_w;
    assign take_w = i_psel && i_penable && o_pready && i_pwrite;
    assign cfg_w  = take_w && (i_paddr == `T16WM_ADDR_CTRL_A || i_paddr == `T16WM_ADDR_PINCTL);
    // Shadow of the fields that steer the pins
    always @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            oma_r  <= 2'h0;
            omb_r  <= 2'h0;
            dira_r <= 1'b0;
            dirb_r <= 1'b0;
        end else if (take_w && i_paddr == `T16WM_ADDR_CTRL_A) begin
            oma_r <= i_pwdata[7:6];
            omb_r <= i_pwdata[5:4];
        end else if (take_w && i_paddr == `T16WM_ADDR_PINCTL) begin
            dira_r <= i_pwdata[0];
            dirb_r <= i_pwdata[1];
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    chk_ready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("pready missing after one wait state");
    chk_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready held too long");
    chk_err_ready: assert property (o_pslverr |-> o_pready)
        else $error("pslverr outside pready");
    chk_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data not zero while idle");
    chk_own_a_field: assert property (
        take_w && i_paddr == `T16WM_ADDR_CTRL_A |-> ##2 (o_cmp_a_own == (oma_r != 2'h0)))
        else $error("pin takeover A wrong");
    chk_own_b_field: assert property (
        take_w && i_paddr == `T16WM_ADDR_CTRL_A |-> ##2 (o_cmp_b_own == (omb_r != 2'h0)))
        else $error("pin takeover B wrong");
    chk_oe_a_gate: assert property (
        cfg_w |-> ##2 (o_cmp_a_oe_n == !(o_cmp_a_own && dira_r)))
        else $error("output enable A wrong");
    chk_oe_b_gate: assert property (
        cfg_w |-> ##2 (o_cmp_b_oe_n == !(o_cmp_b_own && dirb_r)))
        else $error("output enable B wrong");
    chk_out_a_tick: assert property ($changed(o_cmp_a_out) |-> $past(i_tick, 2))
        else $error("output A moved without tick");
    chk_out_b_tick: assert property ($changed(o_cmp_b_out) |-> $past(i_tick, 2))
        else $error("output B moved without tick");
endmodule // t16wm_chk

bind t16wm_timer t16wm_chk u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_tick(i_tick),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_cmp_a_out(o_cmp_a_out), .o_cmp_a_oe_n(o_cmp_a_oe_n), .o_cmp_b_out(o_cmp_b_out),
    .o_cmp_b_oe_n(o_cmp_b_oe_n), .o_cmp_a_own(o_cmp_a_own), .o_cmp_b_own(o_cmp_b_own));

// ==== verif/test_t16wm_timer.sv ====
`timescale 1ns/100ps
`include "t16wm_defines.vh"
module test_t16wm_timer;
    reg         i_clock   = 1'b0;
    reg         i_sys_rst = 1'b1;
    reg         i_tick    = 1'b0;
    reg         i_psel    = 1'b0;
    reg         i_penable = 1'b0;
    reg         i_pwrite  = 1'b0;
    reg  [11:0] i_paddr   = 12'h000;
    reg  [31:0] i_pwdata  = 32'h0;
    wire [31:0] o_prdata;
    wire        o_pready, o_pslverr, o_cmp_a_out, o_cmp_a_oe_n;
    wire        o_cmp_b_out, o_cmp_b_oe_n, o_cmp_a_own, o_cmp_b_own;
    integer     n_errors    = 0;
    integer     comparisons = 0;
    integer     highs;
    integer     k;
    reg  [31:0] rd;
    reg         err;
    reg         v;
    always #4 i_clock = ~i_clock;
    t16wm_timer u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_tick(i_tick),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_cmp_a_out(o_cmp_a_out), .o_cmp_a_oe_n(o_cmp_a_oe_n), .o_cmp_b_out(o_cmp_b_out),
        .o_cmp_b_oe_n(o_cmp_b_oe_n), .o_cmp_a_own(o_cmp_a_own), .o_cmp_b_own(o_cmp_b_own));
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task check(input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_errors);
            if (n_errors == 0 && comparisons > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // Reads after an edge see the values sampled at that edge
    task apb(input wr, input [11:0] addr, input [31:0] data);
        integer t;
        begin
            i_psel   <= 1'b1;
            i_pwrite <= wr;
            i_paddr  <= addr;
            i_pwdata <= data;
            @(posedge i_clock);
            i_penable <= 1'b1;
            t = 0;
            @(posedge i_clock);
            while (o_pready !== 1'b1) begin
                t = t + 1;
                if (t > 20) begin
                    n_errors = n_errors + 1;
                    report_and_stop;
                end
                @(posedge i_clock);
            end
            rd  = o_prdata;
            err = o_pslverr;
            i_psel    <= 1'b0;
            i_penable <= 1'b0;
            @(posedge i_clock);
        end
    endtask
    task rdchk(input [11:0] addr, input [31:0] exp);
        begin
            apb(1'b0, addr, 32'h0);
            check(rd, exp);
        end
    endtask
    // Stop, program in normal mode so compares land at once, restart from zero
    task setup(input [3:0] mode, input [7:0] om, input [15:0] cma, input [15:0] cmb);
        begin
            i_tick <= 1'b0;
            apb(1'b1, `T16WM_ADDR_CTRL_B, 32'h0);
            apb(1'b1, `T16WM_ADDR_CTRL_A, {24'h0, om});
            apb(1'b1, `T16WM_ADDR_CMP_A, {16'h0, cma});
            apb(1'b1, `T16WM_ADDR_CMP_B, {16'h0, cmb});
            apb(1'b1, `T16WM_ADDR_PINCTL, 32'h3);
            apb(1'b1, `T16WM_ADDR_CTRL_B, {27'h0, mode[3:2], 3'h0});
            apb(1'b1, `T16WM_ADDR_CTRL_A, {24'h0, om[7:2], mode[1:0]});
            apb(1'b1, `T16WM_ADDR_COUNT, 32'h0);
            i_tick <= 1'b1;
        end
    endtask
    task highs_b(input integer settle, input integer exp);
        begin
            repeat (settle) @(posedge i_clock);
            highs = 0;
            repeat (16) begin
                @(posedge i_clock);
                highs = highs + o_cmp_b_out;
            end
            check(highs, exp);
        end
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task test_reset;
        begin
            rdchk(`T16WM_ADDR_CTRL_A, 32'h0);
            rdchk(`T16WM_ADDR_CTRL_B, 32'h0);
            check({o_cmp_a_own, o_cmp_b_own, o_cmp_a_oe_n, o_cmp_b_oe_n}, 32'h3);
            apb(1'b1, 12'h020, 32'hFF);
            check(err, 1'b1);
            apb(1'b1, `T16WM_ADDR_CTRL_A, 32'hFFFF_FFFF);
            rdchk(`T16WM_ADDR_CTRL_A, 32'hF3);
            apb(1'b1, `T16WM_ADDR_CTRL_B, 32'hFF);
            rdchk(`T16WM_ADDR_CTRL_B, 32'h18);
            $display("test_reset done");
        end
    endtask
    task test_ctc;
        begin
            setup(4'h4, 8'h40, 16'h0003, 16'h0);
            repeat (8) @(posedge i_clock);
            check({o_cmp_a_own, o_cmp_a_oe_n}, 32'h2);
            v = o_cmp_a_out;
            repeat (4) @(posedge i_clock);
            check(o_cmp_a_out, {31'h0, ~v});
            for (k = 2; k < 4; k = k + 1) begin
                setup(4'h4, {k[1:0], 6'h0}, 16'h0003, 16'h0);
                repeat (12) @(posedge i_clock);
                check(o_cmp_a_out, k - 2);
            end
            apb(1'b1, `T16WM_ADDR_PINCTL, 32'h0);
            @(posedge i_clock);
            check(o_cmp_a_oe_n, 1'b1);
            $display("test_ctc done");
        end
    endtask
    task test_fast_pwm;
        begin
            setup(4'hF, 8'h20, 16'h0004, 16'h0001);
            highs_b(10, 6);
            setup(4'hF, 8'h30, 16'h0004, 16'h0001);
            highs_b(10, 10);
            setup(4'hF, 8'h40, 16'h0004, 16'h0001);
            repeat (8) @(posedge i_clock);
            v = o_cmp_a_out;
            repeat (5) @(posedge i_clock);
            check(o_cmp_a_out, {31'h0, ~v});
            rdchk(`T16WM_ADDR_STATUS, 32'h7);
            i_tick <= 1'b0;
            apb(1'b1, `T16WM_ADDR_STATUS, 32'h7);
            rdchk(`T16WM_ADDR_STATUS, 32'h0);
            apb(1'b0, `T16WM_ADDR_COUNT, 32'h0);
            v = o_cmp_b_out;
            repeat (5) @(posedge i_clock);
            rdchk(`T16WM_ADDR_COUNT, rd);
            check(o_cmp_b_out, v);
            $display("test_fast_pwm done");
        end
    endtask
    task test_dual_slope;
        begin
            setup(4'h9, 8'h20, 16'h0004, 16'h0000);
            highs_b(20, 0);
            setup(4'h9, 8'h20, 16'h0004, 16'h0004);
            highs_b(20, 16);
            apb(1'b1, `T16WM_ADDR_CAPTURE, 32'h4);
            setup(4'hA, 8'h30, 16'h0004, 16'h0000);
            highs_b(20, 16);
            setup(4'h8, 8'h20, 16'h0000, 16'h0000);
            highs_b(20, 0);
            setup(4'hE, 8'h20, 16'h0000, 16'h0001);
            highs_b(10, 6);
            $display("test_dual_slope done");
        end
    endtask
    initial begin
        repeat (16) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        test_reset;
        test_ctc;
        test_fast_pwm;
        test_dual_slope;
        report_and_stop;
    end
endmodule // test_t16wm_timer
